// [logic/gpd_consts.svh]
// Overview of operation
// - primary address zero to thirty, matched only
// - full source handshake per sent byte
// - full acceptor handshake per received byte
// - talk, serial poll; untalk on own listen
// - basic listen; unlisten on own talk
// - service request line and polled status byte
// - remote/local machine with local lockout
// - no parallel poll response ever
// - addressed and universal device clear
// - native set uses 488.2 ascii protocol
// - local to remote on enable plus listen
// - remote ignores panel except output-local
// - output-local returns to local unless locked
// - settings untouched by mode changes
// - remote indicator lit only in remote
// - command type selects native or legacy
// - command type change applies after power cycle
// - legacy rejects native, disables usb and lan
// - separate polarity/output per function
// - device clear flushes input, output, waits
// - interface clear resets talker and listener
// - legacy trigger emits status report
`ifndef GPD_CONSTS_SVH
`define GPD_CONSTS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define GPD_CTRL_OFS   12'h000
`define GPD_STAT_OFS   12'h004
`define GPD_TXD_OFS    12'h008
`define GPD_RXD_OFS    12'h00c
`define GPD_SPOLL_OFS  12'h010
// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define GPD_CTRL_ADDR_LSB 0
`define GPD_CTRL_TYPE_BIT 8
`define GPD_CTRL_RSV_BIT  9
`define GPD_CTRL_EOI_BIT  10
// ---------------------------------------------------------------
// reset values and bus message codes
// ---------------------------------------------------------------
`define GPD_ADDR_RST   5'h01
`define GPD_MAX_ADDR   5'h1e
`define GPD_CMD_GTL    7'h01
`define GPD_CMD_SDC    7'h04
`define GPD_CMD_GET    7'h08
`define GPD_CMD_LLO    7'h11
`define GPD_CMD_DCL    7'h14
`define GPD_CMD_SPE    7'h18
`define GPD_CMD_SPD    7'h19
`define GPD_LAG_BASE   7'h20
`define GPD_UNL        7'h3f
`define GPD_TAG_BASE   7'h40
`define GPD_UNT        7'h5f
`define GPD_SRQ_BIT    6
`endif

// [logic/gpd_pkg.sv]
package gpd_pkg;
  // source handshake states
  typedef enum logic [1:0] {
    GPD_SH_IDLE  = 2'b00,
    GPD_SH_WAIT  = 2'b01,
    GPD_SH_VALID = 2'b10
  } gpd_sh_type;
  // acceptor handshake states
  typedef enum logic [1:0] {
    GPD_AH_READY = 2'b00,
    GPD_AH_TAKE  = 2'b01,
    GPD_AH_HOLD  = 2'b10
  } gpd_ah_type;
  // remote/local states
  typedef enum logic [1:0] {
    GPD_LOCS = 2'b00,
    GPD_REMS = 2'b01,
    GPD_LWLS = 2'b10,
    GPD_RWLS = 2'b11
  } gpd_rl_type;
  // bus pins as seen by the device (open collector, active high here)
  typedef struct packed {
    logic [7:0] dio;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic       atn;
    logic       eoi;
    logic       ifc;
    logic       ren;
  } gpd_bus_in_type;
  // pins the device pulls; enable high while pulling
  typedef struct packed {
    logic [7:0] dio;
    logic [7:0] dio_oe;
    logic       dav_oe;
    logic       nrfd_oe;
    logic       ndac_oe;
    logic       eoi_oe;
    logic       srq_oe;
  } gpd_bus_out_type;
endpackage : gpd_pkg

// [logic/gpd_device.sv]
`include "gpd_consts.svh"
module gpd_device (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire gpd_pkg::gpd_bus_in_type bus_in,
  output gpd_pkg::gpd_bus_out_type     bus_out,
  input  wire logic                    panel_local,
  output logic                         remote_led,
  output logic                         panel_enable,
  output logic                         legacy_active,
  output logic                         other_if_enable,
  output logic                         dev_clear,
  output logic                         trigger,
  output logic                         status_report
);
  import gpd_pkg::*;

  // ---------------------------------------------------------------
  // apb register slave
  // ---------------------------------------------------------------
  logic [4:0]  addr_reg;        // bus_address_setting
  logic        type_reg = 1'b0; // command type requested, 1 = legacy; no reset
  logic        native_command_set; // live set, latched after reset
  logic        type_taken_reg;  // live set captured once
  logic        rsv_reg;         // service request wish
  logic [7:0]  spoll_reg;       // status byte source
  logic [7:0]  txd_reg;         // byte to send
  logic        txeoi_reg;       // send with end
  logic        txreq_reg;       // byte pending for source handshake
  logic [7:0]  rxd_reg;         // last received byte
  logic        rxfull_reg;      // received byte waiting
  logic        rxeoi_reg;       // received byte had end
  logic        tads_reg;        // addressed to talk
  logic        lads_reg;        // addressed to listen
  logic        spms_reg;        // serial poll mode
  gpd_rl_type  rl_reg;          // remote/local state
  gpd_sh_type  sh_reg;
  gpd_ah_type  ah_reg;
  logic        srq_sent_reg;    // srq asserted and not yet polled
  logic        srq_polled_reg;  // polled once; quiet until the wish drops
  logic        acc_w, acc_r;
  logic        sh_done, ah_take;
  logic        clr_evt;         // selected or universal device clear
  logic        ifc_evt;

  assign acc_w = psel && penable && pwrite;
  assign acc_r = psel && penable && !pwrite;

  // single-cycle ready: no wait states on any access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `GPD_CTRL_OFS || paddr == `GPD_STAT_OFS ||
                 paddr == `GPD_TXD_OFS || paddr == `GPD_RXD_OFS || paddr == `GPD_SPOLL_OFS);
    end
  end

  // control register; address above thirty is clipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= `GPD_ADDR_RST;
      rsv_reg   <= 1'b0;
      spoll_reg <= 8'h00;
    end else if (acc_w && pready) begin
      if (paddr == `GPD_CTRL_OFS) begin
        // out-of-range addresses saturate to the top legal value
        addr_reg <= (pwdata[4:0] > `GPD_MAX_ADDR) ? `GPD_MAX_ADDR : pwdata[4:0];
        rsv_reg  <= pwdata[`GPD_CTRL_RSV_BIT];
      end
      if (paddr == `GPD_SPOLL_OFS) begin
        spoll_reg <= pwdata[7:0];
      end
    end
  end

  // requested command type is a stored setting: reset stands for a power
  // cycle, so this flop has no reset or the change could never take hold
  always_ff @(posedge pclk) begin
    if (acc_w && pready && paddr == `GPD_CTRL_OFS) begin
      type_reg <= pwdata[`GPD_CTRL_TYPE_BIT];
    end
  end

  // command type sampled once after reset: reset stands for power cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_taken_reg     <= 1'b0;
      native_command_set <= 1'b1;
    end else if (!type_taken_reg) begin
      type_taken_reg     <= 1'b1;
      native_command_set <= !type_reg;
    end
  end

  // read mux; status shows the block's own state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `GPD_CTRL_OFS:  prdata <= {21'h0, 1'b0, rsv_reg, type_reg, 3'h0, addr_reg};
        `GPD_STAT_OFS:  prdata <= {22'h0, native_command_set, rxeoi_reg, rl_reg, spms_reg,
                                   lads_reg, tads_reg, rxfull_reg, txreq_reg, srq_sent_reg};
        `GPD_TXD_OFS:   prdata <= {24'h0, txd_reg};
        `GPD_RXD_OFS:   prdata <= {24'h0, rxd_reg};
        `GPD_SPOLL_OFS: prdata <= {24'h0, spoll_reg};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command decode from bus while attention is true
  // ---------------------------------------------------------------
  logic [6:0] cmd;
  logic       cmd_evt;
  assign cmd     = bus_in.dio[6:0];
  assign cmd_evt = ah_take && bus_in.atn;
  assign ifc_evt = bus_in.ifc;
  assign clr_evt = cmd_evt && (cmd == `GPD_CMD_DCL || (cmd == `GPD_CMD_SDC && lads_reg));

  // my-address match, used for talk and listen decode
  function automatic logic is_addr(input logic [6:0] c, input logic [6:0] base, input logic [4:0] a);
    is_addr = (c == (base | {2'b00, a}));
  endfunction : is_addr

  // talker/listener addressing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tads_reg <= 1'b0;
      lads_reg <= 1'b0;
      spms_reg <= 1'b0;
    end else if (ifc_evt) begin
      tads_reg <= 1'b0;
      lads_reg <= 1'b0;
      spms_reg <= 1'b0;
    end else if (cmd_evt) begin
      if (is_addr(cmd, `GPD_TAG_BASE, addr_reg)) begin
        tads_reg <= 1'b1;
        lads_reg <= 1'b0;
      end else if (is_addr(cmd, `GPD_LAG_BASE, addr_reg)) begin
        lads_reg <= 1'b1;
        tads_reg <= 1'b0;
      end else if (cmd == `GPD_UNT || (cmd[6:5] == 2'b10)) begin
        tads_reg <= 1'b0; // other talk address or untalk
      end
      if (cmd == `GPD_UNL) begin
        lads_reg <= 1'b0;
      end
      if (cmd == `GPD_CMD_SPE) begin
        spms_reg <= 1'b1;
      end else if (cmd == `GPD_CMD_SPD) begin
        spms_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // acceptor handshake
  // ---------------------------------------------------------------
  // accept commands always, data only when listening with room
  logic ah_room;
  assign ah_room = bus_in.atn || (lads_reg && !rxfull_reg);
  assign ah_take = (ah_reg == GPD_AH_READY) && bus_in.dav && ah_room;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ah_reg <= GPD_AH_READY;
    end else begin
      unique case (ah_reg)
        GPD_AH_READY: if (ah_take) ah_reg <= GPD_AH_HOLD;
        GPD_AH_HOLD:  if (!bus_in.dav) ah_reg <= GPD_AH_READY;
        default:      ah_reg <= GPD_AH_READY;
      endcase
    end
  end

  // received data byte; device clear discards it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_reg    <= 8'h00;
      rxfull_reg <= 1'b0;
      rxeoi_reg  <= 1'b0;
    end else if (ah_take && !bus_in.atn) begin
      rxd_reg    <= bus_in.dio;
      rxfull_reg <= 1'b1; // new byte beats a same-cycle read
      rxeoi_reg  <= bus_in.eoi;
    end else if (clr_evt || (acc_r && pready && paddr == `GPD_RXD_OFS)) begin
      rxfull_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // source handshake: data, then status byte during serial poll
  // ---------------------------------------------------------------
  logic talk_ok;
  assign talk_ok = tads_reg && !bus_in.atn;
  // accepted only after our own dav went out: ndac false with no dav means no acceptor
  assign sh_done = (sh_reg == GPD_SH_VALID) && bus_out.dav_oe && !bus_in.ndac;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= GPD_SH_IDLE;
    end else if (ifc_evt || !talk_ok) begin
      sh_reg <= GPD_SH_IDLE;
    end else begin
      unique case (sh_reg)
        GPD_SH_IDLE:  if (spms_reg || txreq_reg) sh_reg <= GPD_SH_WAIT;
        GPD_SH_WAIT:  if (!bus_in.nrfd) sh_reg <= GPD_SH_VALID;
        GPD_SH_VALID: if (sh_done) sh_reg <= GPD_SH_IDLE;
        default:      sh_reg <= GPD_SH_IDLE;
      endcase
    end
  end

  // transmit byte holding; clear and ifc drop the output queue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_reg   <= 8'h00;
      txeoi_reg <= 1'b0;
      txreq_reg <= 1'b0;
    end else if (clr_evt || ifc_evt) begin
      txreq_reg <= 1'b0;
    end else if (acc_w && pready && paddr == `GPD_TXD_OFS && !txreq_reg) begin
      txd_reg   <= pwdata[7:0];
      txeoi_reg <= pwdata[`GPD_CTRL_EOI_BIT];
      txreq_reg <= 1'b1;
    end else if (sh_done && !spms_reg) begin
      txreq_reg <= 1'b0;
    end
  end

  // service request: srq held until polled byte goes out, then kept off
  // until software withdraws the wish, so one wish asks only once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srq_sent_reg   <= 1'b0;
      srq_polled_reg <= 1'b0;
    end else if (!rsv_reg) begin
      srq_sent_reg   <= 1'b0;
      srq_polled_reg <= 1'b0;
    end else if (sh_done && spms_reg) begin
      srq_sent_reg   <= 1'b0;
      srq_polled_reg <= 1'b1;
    end else if (!srq_polled_reg) begin
      srq_sent_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // remote/local with lockout
  // ---------------------------------------------------------------
  logic my_listen;
  assign my_listen = cmd_evt && is_addr(cmd, `GPD_LAG_BASE, addr_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rl_reg <= GPD_LOCS;
    end else if (!bus_in.ren) begin
      rl_reg <= GPD_LOCS;
    end else begin
      unique case (rl_reg)
        GPD_LOCS: if (my_listen) rl_reg <= GPD_REMS;
                  else if (cmd_evt && cmd == `GPD_CMD_LLO) rl_reg <= GPD_LWLS;
        GPD_LWLS: if (my_listen) rl_reg <= GPD_RWLS;
        GPD_REMS: if (cmd_evt && cmd == `GPD_CMD_LLO) rl_reg <= GPD_RWLS;
                  else if (panel_local || (cmd_evt && cmd == `GPD_CMD_GTL && lads_reg))
                    rl_reg <= GPD_LOCS;
        GPD_RWLS: if (cmd_evt && cmd == `GPD_CMD_GTL && lads_reg) rl_reg <= GPD_LWLS;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin and user outputs, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_out         <= '0;
      remote_led      <= 1'b0;
      panel_enable    <= 1'b1;
      legacy_active   <= 1'b0;
      other_if_enable <= 1'b1;
      dev_clear       <= 1'b0;
      trigger         <= 1'b0;
      status_report   <= 1'b0;
    end else begin
      // parallel poll lines are never pulled: dio only in source phase
      bus_out.dio     <= spms_reg ? {spoll_reg[7], srq_sent_reg, spoll_reg[5:0]} : txd_reg;
      bus_out.dio_oe  <= {8{sh_reg != GPD_SH_IDLE && talk_ok}};
      bus_out.dav_oe  <= (sh_reg == GPD_SH_VALID) && talk_ok && bus_in.ndac;
      bus_out.eoi_oe  <= (sh_reg != GPD_SH_IDLE) && talk_ok && txeoi_reg && !spms_reg;
      // an idle acceptor lets both lines go, else our own talker would stall
      bus_out.nrfd_oe <= (lads_reg || bus_in.atn) && !((ah_reg == GPD_AH_READY) && ah_room);
      bus_out.ndac_oe <= (lads_reg || bus_in.atn) && (ah_reg != GPD_AH_HOLD);
      bus_out.srq_oe  <= srq_sent_reg;
      remote_led      <= rl_reg[0];
      // only the output-local switch works in remote; settings live elsewhere
      panel_enable    <= !rl_reg[0];
      legacy_active   <= !native_command_set;
      other_if_enable <= native_command_set;
      dev_clear       <= clr_evt;
      trigger         <= cmd_evt && cmd == `GPD_CMD_GET && lads_reg;
      status_report   <= cmd_evt && cmd == `GPD_CMD_GET && lads_reg && !native_command_set;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_range: assert property (addr_reg <= `GPD_MAX_ADDR) else $error("address out of range");
  a_dav_after_rfd: assert property ($rose(bus_out.dav_oe) |-> $past(sh_reg) == GPD_SH_VALID)
    else $error("dav without ready");
  a_ndac_hold: assert property (ah_take |=> ah_reg == GPD_AH_HOLD ##1 !bus_out.ndac_oe)
    else $error("acceptor did not release ndac");
  a_untalk_mla: assert property (my_listen && !ifc_evt |=> !tads_reg) else $error("talker kept");
  a_unlisten_mta: assert property (cmd_evt && !ifc_evt && is_addr(cmd, `GPD_TAG_BASE, addr_reg) |=> !lads_reg)
    else $error("listener kept");
  a_srq_pin: assert property (srq_sent_reg |=> bus_out.srq_oe) else $error("srq not driven");
  a_ren_drop: assert property (!bus_in.ren |=> rl_reg == GPD_LOCS ##1 !remote_led)
    else $error("remote held without ren");
  a_lockout_hold: assert property (rl_reg == GPD_RWLS && bus_in.ren && !cmd_evt |=> rl_reg == GPD_RWLS)
    else $error("lockout escaped");
  a_ifc_clear: assert property (ifc_evt |=> !tads_reg && !lads_reg ##1 bus_out.dio_oe == 8'h00)
    else $error("ifc did not clear");
  a_clear_flush: assert property (clr_evt |=> !txreq_reg && dev_clear) else $error("clear missed");

  c_byte_sent:  cover property (sh_done && !spms_reg);
  c_poll_sent:  cover property (sh_done && spms_reg);
  c_lockout:    cover property (rl_reg == GPD_RWLS);
  c_byte_taken: cover property (ah_take && !bus_in.atn);
endmodule : gpd_device

// [bench/gpd_ctl_model.sv]
// ---------------------------------------------------------------
// bus controller model: sources commands and data, accepts bytes
// ---------------------------------------------------------------
module gpd_ctl_model (
  input  wire logic                    pclk,
  input  wire gpd_pkg::gpd_bus_out_type bus_out,
  output gpd_pkg::gpd_bus_in_type      bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpd_pkg::*;
  logic [7:0] c_dio  = 8'h00; // controller data pull
  logic       c_dav  = 1'b0;  // controller source strobe
  logic       c_nrfd = 1'b1;  // not ready while not listening
  logic       c_ndac = 1'b1;  // not accepted while not listening
  logic       c_atn  = 1'b0;
  logic       c_eoi  = 1'b0;
  logic       c_ifc  = 1'b0;
  logic       c_ren  = 1'b0;
  // open collector: a released line reads false through the terminators
  assign bus_in.dio  = c_dio | (bus_out.dio & bus_out.dio_oe);
  assign bus_in.dav  = c_dav | bus_out.dav_oe;
  assign bus_in.nrfd = c_nrfd | bus_out.nrfd_oe;
  assign bus_in.ndac = c_ndac | bus_out.ndac_oe;
  assign bus_in.eoi  = c_eoi | bus_out.eoi_oe;
  assign bus_in.atn  = c_atn;
  assign bus_in.ifc  = c_ifc;
  assign bus_in.ren  = c_ren;
  // pick a handshake line by index: 0 nrfd, 1 ndac, 2 dav
  function automatic logic ln(input int k);
    ln = (k == 0) ? bus_in.nrfd : (k == 1) ? bus_in.ndac : bus_in.dav;
  endfunction : ln
  // bounded wait so a stuck handshake ends the run instead of hanging
  task automatic wt(input int k, input logic v);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (ln(k) === v) break;
    end
    if (i == 200) begin
      testbench.num_errors++;
      testbench.wrap_up();
    end
  endtask : wt
  // one byte as source; the only host on this bus
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    @(posedge pclk);
    c_nrfd <= 1'b0;
    c_ndac <= 1'b0;
    c_atn  <= atn;
    c_eoi  <= eoi;
    c_dio  <= b;
    wt(0, 1'b0);
    c_dav <= 1'b1;
    wt(1, 1'b0);
    c_dav <= 1'b0;
    c_dio <= 8'h00;
    c_eoi <= 1'b0;
    @(posedge pclk);
    c_atn <= 1'b0;
  endtask : send
  // one byte as acceptor; holds not-ready afterwards to stall the talker
  task automatic recv(output logic [7:0] b, output logic e);
    @(posedge pclk);
    c_ndac <= 1'b1;
    c_nrfd <= 1'b0;
    wt(2, 1'b1);
    b = bus_in.dio;
    e = bus_in.eoi;
    c_nrfd <= 1'b1;
    c_ndac <= 1'b0;
    wt(2, 1'b0);
    c_ndac <= 1'b1;
  endtask : recv
  task automatic pulse_ifc();
    @(posedge pclk);
    c_ifc <= 1'b1;
    repeat (3) @(posedge pclk);
    c_ifc <= 1'b0;
  endtask : pulse_ifc
  task automatic set_ren(input logic v);
    @(posedge pclk);
    c_ren <= v;
  endtask : set_ren
  // parallel poll request: attention with end-or-identify
  task automatic idy(output logic seen);
    @(posedge pclk);
    c_atn <= 1'b1;
    c_eoi <= 1'b1;
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      seen = seen | (|bus_out.dio_oe);
    end
    c_atn <= 1'b0;
    c_eoi <= 1'b0;
  endtask : idy
endmodule : gpd_ctl_model

// [bench/testbench.sv]
`include "gpd_consts.svh"
`define CHK(nm, x, g) begin cmp_count++; if ((g) !== (x)) begin num_errors++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, x, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpd_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic            pclk = 1'b0, presetn = 1'b0, panel_local = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0, prdata;
  logic            pready, pslverr, remote_led, panel_enable, legacy_active;
  logic            other_if_enable, dev_clear, trigger, status_report;
  gpd_bus_in_type  bus_in;
  gpd_bus_out_type bus_out;
  int              num_errors = 0, cmp_count = 0, n_clr = 0, n_trg = 0, n_rpt = 0;
  logic [31:0]     r;
  logic [7:0]      b;
  logic            e;
  localparam logic [7:0] MLA = {1'b0, `GPD_LAG_BASE} + 8'h05; // own listen address
  localparam logic [7:0] MTA = {1'b0, `GPD_TAG_BASE} + 8'h05; // own talk address
  typedef struct packed {logic [7:0] cmd; logic [1:0] tl;} gpd_row_type;
  // addressing rows: command byte, expected {listen, talk}
  gpd_row_type rows [6] = '{'{MLA, 2'b10}, '{MTA, 2'b01}, '{MLA, 2'b10},
                            '{{1'b0, `GPD_UNL}, 2'b00}, '{MLA + 8'h01, 2'b00}, '{MTA, 2'b01}};
  always #4 pclk = ~pclk;
  // one-cycle pulses are counted so a scenario can check them later
  always @(posedge pclk) begin
    if (dev_clear === 1'b1) n_clr++;
    if (trigger === 1'b1) n_trg++;
    if (status_report === 1'b1) n_rpt++;
  end
  gpd_device i_gpd_device (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_in(bus_in), .bus_out(bus_out), .panel_local(panel_local),
    .remote_led(remote_led), .panel_enable(panel_enable), .legacy_active(legacy_active),
    .other_if_enable(other_if_enable), .dev_clear(dev_clear), .trigger(trigger),
    .status_report(status_report));
  gpd_ctl_model i_gpd_ctl_model (.pclk(pclk), .bus_out(bus_out), .bus_in(bus_in));
  // ---------------------------------------------------------------
  // apb master, checks and closing report
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin num_errors++; wrap_up(); end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, x, input string nm);
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r & m);
  endtask : rchk
  task automatic stat(input logic [31:0] m, x, input string nm);
    rchk(`GPD_STAT_OFS, m, x, nm);
  endtask : stat
  task automatic do_reset();
    @(posedge pclk) presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // set enables follow the type latched at the first edge, one edge later
    repeat (3) @(posedge pclk);
  endtask : do_reset
  task automatic cmd(input logic [6:0] c);
    i_gpd_ctl_model.send({1'b0, c}, 1'b1, 1'b0);
  endtask : cmd
  task automatic panel(input logic v);
    @(posedge pclk) panel_local <= v;
    repeat (3) @(posedge pclk);
  endtask : panel
  // watchdog against a hang anywhere
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
  initial begin
    do_reset();
    `CHK("ndac idle", 1'b0, bus_out.ndac_oe);
    `CHK("nrfd idle", 1'b0, bus_out.nrfd_oe);
    `CHK("led rst", 1'b0, remote_led);
    `CHK("usb lan rst", 1'b1, other_if_enable);
    rchk(`GPD_CTRL_OFS, 32'h1f, {27'h0, `GPD_ADDR_RST}, "addr rst");
    stat(32'h2c0, 32'h200, "stat rst");
    wr(`GPD_CTRL_OFS, 32'h1f);
    rchk(`GPD_CTRL_OFS, 32'h1f, {27'h0, `GPD_MAX_ADDR}, "addr sat");
    wr(`GPD_CTRL_OFS, 32'h05);
    apb(1'b0, 12'h020, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e);
    `CHK("unmapped data", 32'h0, r);
    // table of addressing commands
    foreach (rows[k]) begin
      cmd(rows[k].cmd[6:0]);
      stat(32'h18, {27'h0, rows[k].tl, 3'h0}, "talk listen");
    end
    // received data byte with end flag
    cmd(MLA[6:0]);
    i_gpd_ctl_model.send(8'h5a, 1'b0, 1'b1);
    stat(32'h104, 32'h104, "rx full");
    rchk(`GPD_RXD_OFS, 32'hff, 32'h5a, "rx byte");
    stat(32'h4, 32'h0, "rx clr");
    cmd(`GPD_CMD_SDC);
    cmd(`GPD_CMD_DCL);
    `CHK("clears", 2, n_clr);
    cmd(`GPD_CMD_GET);
    `CHK("trigger", 1, n_trg);
    `CHK("native report", 0, n_rpt);
    // remote, local, lockout walk
    i_gpd_ctl_model.set_ren(1'b1);
    cmd(MLA[6:0]);
    repeat (2) @(posedge pclk);
    `CHK("led remote", 1'b1, remote_led);
    `CHK("panel off", 1'b0, panel_enable);
    stat(32'hc0, 32'h40, "rl remote");
    panel(1'b1);
    `CHK("panel local", 1'b0, remote_led);
    panel(1'b0);
    cmd(MLA[6:0]);
    cmd(`GPD_CMD_LLO);
    stat(32'hc0, 32'hc0, "rl lock");
    panel(1'b1);
    `CHK("lock holds", 1'b1, remote_led);
    panel(1'b0);
    cmd(`GPD_CMD_GTL);
    stat(32'hc0, 32'h80, "rl gtl");
    `CHK("led gtl", 1'b0, remote_led);
    cmd(MLA[6:0]);
    i_gpd_ctl_model.set_ren(1'b0);
    stat(32'hc0, 32'h0, "ren drop");
    rchk(`GPD_CTRL_OFS, 32'h1f, 32'h05, "kept");
    // talker byte, then serial poll with service request
    cmd(MTA[6:0]);
    wr(`GPD_TXD_OFS, 32'h4a5);
    i_gpd_ctl_model.recv(b, e);
    `CHK("tx byte", 8'ha5, b);
    `CHK("tx eoi", 1'b1, e);
    stat(32'h2, 32'h0, "tx done");
    wr(`GPD_SPOLL_OFS, 32'h03);
    wr(`GPD_CTRL_OFS, 32'h205);
    repeat (3) @(posedge pclk);
    `CHK("srq", 1'b1, bus_out.srq_oe);
    cmd(`GPD_CMD_SPE);
    cmd(MTA[6:0]);
    i_gpd_ctl_model.recv(b, e);
    `CHK("poll byte", 8'h43, b);
    i_gpd_ctl_model.recv(b, e);
    `CHK("poll again", 8'h03, b);
    `CHK("srq quiet", 1'b0, bus_out.srq_oe);
    cmd(`GPD_CMD_SPD);
    wr(`GPD_CTRL_OFS, 32'h005);
    i_gpd_ctl_model.idy(e);
    `CHK("no ppoll", 1'b0, e);
    i_gpd_ctl_model.pulse_ifc();
    stat(32'h18, 32'h0, "ifc");
    // command type takes effect only after reset
    wr(`GPD_CTRL_OFS, 32'h105);
    repeat (2) @(posedge pclk);
    `CHK("type held", 1'b0, legacy_active);
    stat(32'h200, 32'h200, "native kept");
    do_reset();
    `CHK("legacy", 1'b1, legacy_active);
    `CHK("usb lan off", 1'b0, other_if_enable);
    stat(32'h200, 32'h0, "native off");
    cmd(`GPD_LAG_BASE | {2'b00, `GPD_ADDR_RST});
    cmd(`GPD_CMD_GET);
    `CHK("legacy report", 1, n_rpt);
    // a legacy host pauses only after output changes; none are sent here
    wrap_up();
  end
endmodule : testbench
